// File: core/fmrd_decoder.sv
// Floating mode/range decoder: serial command intake, mode/range decode, forcing waveform.
// Assumes opto-coupled pins asynchronous to core_clk_i and an AXI4-Lite master.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fmrd_regs.svh"

module fmrd_decoder
  import fmrd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Opto-coupled pins
  input wire logic serial_data_i,
  input wire logic serial_strobe_i,
  input wire logic clk_1m6_i,
  input wire logic display_segment_test_i,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drives to the floating analog circuits
  output fmrd_drive_t drives_o,
  output logic integrator_force_wave_o,
  output logic force_rise_edge_pulse_n_o,
  output logic force_fall_edge_pulse_n_o
);

  // Pin synchronisers: bit 0 data, 1 strobe, 2 clock, 3 display test
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [2:0] pin_prev_reg;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
      pin_prev_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {display_segment_test_i, clk_1m6_i, serial_strobe_i, serial_data_i};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg[2:0];
    end
  end

  logic strobe_rise;
  logic clk_rise;
  logic display_segment_test;
  assign strobe_rise = pin_sync_reg[1] & ~pin_prev_reg[1];
  assign clk_rise = pin_sync_reg[2] & ~pin_prev_reg[2];
  assign display_segment_test = pin_sync_reg[3];

  // Control register
  logic load_en_reg;

  // Serial intake and noise rejection
  logic [7:0] shift_reg;
  logic [3:0] pulse_cnt_reg;
  logic [10:0] gap_cnt_reg;
  logic [7:0] reject_cnt_reg;
  logic load_pulse;
  logic gap_done;

  assign gap_done = (pulse_cnt_reg != 4'h0) && (gap_cnt_reg == 11'(`FMRD_GAP_CYCLES));
  assign load_pulse = gap_done && (pulse_cnt_reg == `FMRD_WORD_BITS) && load_en_reg;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_reg <= 8'h00;
    end else if (strobe_rise) begin
      shift_reg <= {shift_reg[6:0], pin_sync_reg[0]};
    end
  end

  // Extra pulses saturate the count so an over-long burst is refused too
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulse_cnt_reg <= 4'h0;
      gap_cnt_reg <= 11'h000;
    end else if (strobe_rise) begin
      gap_cnt_reg <= 11'h000;
      if (pulse_cnt_reg != `FMRD_CNT_SAT) begin
        pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
      end
    end else if (gap_done) begin
      pulse_cnt_reg <= 4'h0;
      gap_cnt_reg <= 11'h000;
    end else if (pulse_cnt_reg != 4'h0) begin
      gap_cnt_reg <= gap_cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reject_cnt_reg <= 8'h00;
    end else if (gap_done && (pulse_cnt_reg != `FMRD_WORD_BITS)) begin
      if (reject_cnt_reg != 8'hff) begin
        reject_cnt_reg <= reject_cnt_reg + 8'h01;
      end
    end
  end

  // Holding latches, unchanged until the next good burst while load_en_reg is set
  fmrd_setting_t setting_reg;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      setting_reg <= '0;
    end else if (load_pulse) begin
      setting_reg.mode <= shift_reg[`FMRD_MODE_MSB:`FMRD_MODE_LSB];
      setting_reg.range <= shift_reg[`FMRD_RANGE_MSB:`FMRD_RANGE_LSB];
    end
  end

  // Mode decode
  logic [3:0] eff_code;
  logic [15:0] line_n;
  logic [2:0] rng;
  logic dc_n;
  logic ac_n;
  logic ohms_n;
  logic [3:0] test_n;

  assign eff_code = display_segment_test ? `FMRD_CODE_TEST1 : setting_reg.mode;
  assign line_n = ~(16'h0001 << eff_code);
  assign dc_n = &line_n[3:0];
  assign ac_n = &line_n[7:4];
  assign ohms_n = &line_n[11:8];
  assign test_n = line_n[15:12];
  assign rng = setting_reg.range[2:0];

  fmrd_drive_t drive_next;

  always_comb begin
    drive_next = '0;
    drive_next.ratio_reference_relay = setting_reg.range[`FMRD_RATIO_BIT];
    drive_next.dc_mode_n = dc_n;
    drive_next.ac_mode_n = ac_n;
    drive_next.ohms_mode_n = ohms_n;
    drive_next.selftest_n = test_n;
    // AC path and 10 V ac self-check scaling
    if (!ac_n) begin
      drive_next.ac_kilo_atten_relay = (rng == `FMRD_RNG_1000V);
      drive_next.ac_attenuator_control = (rng == `FMRD_RNG_10V) ||
                                         (rng == `FMRD_RNG_100V);
      drive_next.ac_direct_path_relay = !drive_next.ac_kilo_atten_relay &&
                                        !drive_next.ac_attenuator_control;
      drive_next.ac_buffer_x10 = (rng == `FMRD_RNG_10V);
    end else if (!test_n[2]) begin
      drive_next.ac_direct_path_relay = 1'b1;
    end
    // Ohms current generator
    if (!ohms_n) begin
      drive_next.high_current_switch = (rng < `FMRD_RNG_OHM_MID_LO);
      drive_next.mid_current_switch = (rng >= `FMRD_RNG_OHM_MID_LO) &&
                                      (rng <= `FMRD_RNG_OHM_MID_HI);
    end else if (!test_n[3]) begin
      drive_next.high_current_switch = 1'b1;
      drive_next.ohms_selfcheck_relay = 1'b1;
    end
    // DC ranging; dc self-checks read on the lowest gain range
    if (!dc_n) begin
      unique case (rng)
        `FMRD_RNG_100MV: drive_next.dc_gain_switch = 4'h1;
        `FMRD_RNG_1V: drive_next.dc_gain_switch = 4'h2;
        `FMRD_RNG_10V: drive_next.dc_gain_switch = 4'h4;
        `FMRD_RNG_100V: drive_next.dc_gain_switch = 4'h2;
        `FMRD_RNG_1000V: drive_next.dc_gain_switch = 4'h4;
        default: drive_next.dc_gain_switch = 4'h8;
      endcase
      drive_next.dc_input_atten = (rng == `FMRD_RNG_100V) ||
                                  (rng == `FMRD_RNG_1000V);
    end else if (!test_n[0] || !test_n[1] || !test_n[3]) begin
      drive_next.dc_gain_switch = 4'h4;
    end
  end

  // Registered so relay lines never see decode glitches
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drives_o <= '{dc_mode_n: 1'b1, ac_mode_n: 1'b1, ohms_mode_n: 1'b1,
                    selftest_n: 4'hf, default: '0};
    end else begin
      drives_o <= drive_next;
    end
  end

  // Forcing waveform divider chain, clocked by enables only
  logic [3:0] div_a_reg;
  logic [3:0] div_b_reg;
  logic [3:0] div_c_reg;
  logic en_b;
  logic en_c;
  logic wave_dly_reg;

  assign en_b = clk_rise && (div_a_reg == `FMRD_DIV_A_LAST);
  assign en_c = en_b && (div_b_reg == `FMRD_DIV_B_LAST);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_a_reg <= 4'h0;
      div_b_reg <= 4'h0;
      div_c_reg <= 4'h0;
    end else begin
      if (clk_rise) begin
        div_a_reg <= div_a_reg + 4'h1;
      end
      if (en_b) begin
        div_b_reg <= (div_b_reg == `FMRD_DIV_B_LAST) ? 4'h0 : div_b_reg + 4'h1;
      end
      if (en_c) begin
        div_c_reg <= (div_c_reg == `FMRD_DIV_C_LAST) ? 4'h0 : div_c_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      integrator_force_wave_o <= 1'b0;
      wave_dly_reg <= 1'b0;
      force_rise_edge_pulse_n_o <= 1'b1;
      force_fall_edge_pulse_n_o <= 1'b1;
    end else begin
      integrator_force_wave_o <= (div_c_reg >= `FMRD_DIV_C_HALF);
      wave_dly_reg <= integrator_force_wave_o;
      force_rise_edge_pulse_n_o <= ~(integrator_force_wave_o & ~wave_dly_reg);
      force_fall_edge_pulse_n_o <= ~(~integrator_force_wave_o & wave_dly_reg);
    end
  end

  // AXI4-Lite write: address and data taken in either order
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FMRD_RESP_OKAY;
      load_en_reg <= `FMRD_CTRL_RESET;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_reg == `FMRD_CTRL_OFS) begin
        s_axi_bresp <= `FMRD_RESP_OKAY;
        if (w_strb_reg[0]) begin
          load_en_reg <= w_data_reg[`FMRD_CTRL_LOAD_EN_BIT];
        end
      end else if ((aw_addr_reg == `FMRD_STATUS_OFS) || (aw_addr_reg == `FMRD_DRIVES_OFS)) begin
        s_axi_bresp <= `FMRD_RESP_OKAY;
      end else begin
        s_axi_bresp <= `FMRD_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FMRD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FMRD_RESP_OKAY;
      if (s_axi_araddr == `FMRD_CTRL_OFS) begin
        s_axi_rdata <= {31'h0, load_en_reg};
      end else if (s_axi_araddr == `FMRD_STATUS_OFS) begin
        s_axi_rdata <= {12'h000, pulse_cnt_reg, reject_cnt_reg, setting_reg};
      end else if (s_axi_araddr == `FMRD_DRIVES_OFS) begin
        s_axi_rdata <= {12'h000, drives_o};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `FMRD_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: core/fmrd_pkg.sv
// Types shared by the floating mode/range decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package fmrd_pkg;

  // All relay and switch drives leaving the decoder
  typedef struct packed {
    logic ratio_reference_relay;
    logic dc_mode_n;
    logic ac_mode_n;
    logic ohms_mode_n;
    logic [3:0] selftest_n;
    logic ac_direct_path_relay;
    logic ac_kilo_atten_relay;
    logic ac_attenuator_control;
    logic ac_buffer_x10;
    logic high_current_switch;
    logic mid_current_switch;
    logic ohms_selfcheck_relay;
    logic [3:0] dc_gain_switch;
    logic dc_input_atten;
  } fmrd_drive_t;

  // Latched settings of the current reading
  typedef struct packed {
    logic [3:0] range;
    logic [3:0] mode;
  } fmrd_setting_t;

endpackage

// File: core/fmrd_regs.svh
// Register offsets, reset values and timing figures of the floating mode/range decoder.
// Assumes a 200 MHz core clock and a 12-bit AXI4-Lite byte address.
`ifndef FMRD_REGS_SVH
`define FMRD_REGS_SVH

// Register byte offsets
`define FMRD_CTRL_OFS 12'h000
`define FMRD_STATUS_OFS 12'h004
`define FMRD_DRIVES_OFS 12'h008

// Control register fields and reset value
`define FMRD_CTRL_LOAD_EN_BIT 0
`define FMRD_CTRL_RESET 1'b1

// AXI responses
`define FMRD_RESP_OKAY 2'b00
`define FMRD_RESP_SLVERR 2'b10

// Serial word layout
`define FMRD_WORD_BITS 4'h8
`define FMRD_CNT_SAT 4'h9
`define FMRD_MODE_MSB 3
`define FMRD_MODE_LSB 0
`define FMRD_RANGE_MSB 7
`define FMRD_RANGE_LSB 4
`define FMRD_RATIO_BIT 3

// Burst gap timing: a burst is complete after this much strobe silence
`define FMRD_CLK_MHZ 200
`define FMRD_BURST_GAP_NS 5000
`define FMRD_GAP_CYCLES ((`FMRD_BURST_GAP_NS * `FMRD_CLK_MHZ + 999) / 1000)

// Forcing waveform divider: 1.6 MHz / 16 / 10 / 10 = 1 kHz
`define FMRD_DIV_A_LAST 4'hf
`define FMRD_DIV_B_LAST 4'h9
`define FMRD_DIV_C_LAST 4'h9
`define FMRD_DIV_C_HALF 4'h5

// Mode decoder codes
`define FMRD_CODE_TEST1 4'hc
`define FMRD_CODE_TEST2 4'hd
`define FMRD_CODE_TEST3 4'he
`define FMRD_CODE_TEST4 4'hf

// Range codes
`define FMRD_RNG_100MV 3'h0
`define FMRD_RNG_1V 3'h1
`define FMRD_RNG_10V 3'h2
`define FMRD_RNG_100V 3'h3
`define FMRD_RNG_1000V 3'h4
`define FMRD_RNG_OHM_MID_LO 3'h4
`define FMRD_RNG_OHM_MID_HI 3'h5

`endif

// File: dv/floating_mode_range_decoder_test.sv
// Self-checking bench for the floating mode/range decoder.
// Assumes the controller model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module floating_mode_range_decoder_test
  import fmrd_pkg::*;
;
  logic core_clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic display_segment_test_i = 1'h0;
  logic clk_1m6, sdata, sstrobe, wave, rise_n, fall_n;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  fmrd_drive_t drives;
  logic [7:0] cur = 8'h0;
  int n_fail = 0;
  int checks_done = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  fmrd_ctl_model ctl (.clk_1m6_o(clk_1m6), .serial_data_o(sdata), .serial_strobe_o(sstrobe));
  fmrd_decoder dut (.core_clk_i, .arst_n_i, .serial_data_i(sdata), .serial_strobe_i(sstrobe),
    .clk_1m6_i(clk_1m6), .display_segment_test_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drives_o(drives),
    .integrator_force_wave_o(wave), .force_rise_edge_pulse_n_o(rise_n),
    .force_fall_edge_pulse_n_o(fall_n));
  task automatic report_and_stop;
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    k = 0;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      k++;
    end while (s_axi_bvalid !== 1'h1 && k < 50);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    if (k >= 50) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [1:0] er);
    int k;
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    k = 0;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      k++;
    end while (s_axi_rvalid !== 1'h1 && k < 50);
    s_axi_rready <= 1'h0;
    rdat = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    if (k >= 50) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  function automatic fmrd_drive_t exp_drv(input logic [3:0] m, input logic [3:0] r);
    fmrd_drive_t d;
    logic [2:0] c;
    d = '0;
    c = r[2:0];
    d.ratio_reference_relay = r[3];
    d.dc_mode_n = m[3] | m[2];
    d.ac_mode_n = !(m[3:2] == 2'h1);
    d.ohms_mode_n = !(m[3:2] == 2'h2);
    d.selftest_n = (m[3:2] == 2'h3) ? ~(4'h1 << m[1:0]) : 4'hf;
    if (!d.ac_mode_n || m == 4'he) begin
      d.ac_kilo_atten_relay = !d.ac_mode_n && c == 3'h4;
      d.ac_attenuator_control = !d.ac_mode_n && (c == 3'h2 || c == 3'h3);
      d.ac_buffer_x10 = !d.ac_mode_n && c == 3'h2;
      d.ac_direct_path_relay = !(d.ac_kilo_atten_relay || d.ac_attenuator_control);
    end
    if (!d.ohms_mode_n || m == 4'hf) begin
      d.high_current_switch = m == 4'hf || c < 3'h4;
      d.mid_current_switch = !d.ohms_mode_n && c[2:1] == 2'h2;
      d.ohms_selfcheck_relay = m == 4'hf;
    end
    if (!d.dc_mode_n) begin
      d.dc_gain_switch = (c == 3'h0) ? 4'h1 : (c == 3'h1 || c == 3'h3) ? 4'h2 :
        (c == 3'h2 || c == 3'h4) ? 4'h4 : 4'h8;
      d.dc_input_atten = c == 3'h3 || c == 3'h4;
    end
    if (m == 4'hc || m == 4'hd || m == 4'hf) begin
      d.dc_gain_switch = 4'h4;
    end
    return d;
  endfunction
  // Gain switches are left open to judgment in ohms mode
  task automatic chk_drv(input logic [7:0] w);
    logic [19:0] mk;
    mk = (w[3:2] == 2'h2) ? 20'hfffe0 : 20'hfffff;
    chk({12'h0, drives & mk}, {12'h0, exp_drv(w[3:0], w[7:4]) & mk});
  endtask
  task automatic t_reset;
    axi_rd(12'h000, 2'h0);
    chk(rdat, 32'h1);
    axi_rd(12'h004, 2'h0);
    chk(rdat, 32'h0);
    axi_rd(12'h008, 2'h0);
    chk(rdat, {12'h0, exp_drv(4'h0, 4'h0)});
    axi_rd(12'h00c, 2'h2);
    chk(rdat, 32'h0);
  endtask
  task automatic t_modes;
    logic [2:0] c;
    for (int j = 0; j < 28; j++) begin
      c = 3'((j * 3 + (j >= 16 ? 4 : 0)) % 8);
      cur = {j[1], c, j[3:0]};
      ctl.send(cur, 8);
      @(posedge core_clk_i);
      chk_drv(cur);
      axi_rd(12'h004, 2'h0);
      chk({24'h0, rdat[7:0]}, {24'h0, cur});
    end
  endtask
  task automatic t_load_en;
    axi_wr(12'h000, 32'h0, 2'h0);
    axi_rd(12'h000, 2'h0);
    chk(rdat, 32'h0);
    ctl.send(8'h43, 8);
    @(posedge core_clk_i);
    chk_drv(cur);
    axi_wr(12'h000, 32'h1, 2'h0);
    axi_wr(12'h010, 32'h1, 2'h2);
  endtask
  task automatic t_reject;
    logic [7:0] rc;
    axi_rd(12'h004, 2'h0);
    rc = rdat[15:8];
    ctl.send(8'h5a, 7);
    ctl.send(8'h5a, 9);
    @(posedge core_clk_i);
    chk_drv(cur);
    axi_rd(12'h004, 2'h0);
    chk({24'h0, rdat[15:8]}, {24'h0, rc + 8'h2});
    ctl.send(8'h5a, 8);
    cur = 8'h5a;
    @(posedge core_clk_i);
    chk_drv(cur);
  endtask
  task automatic t_lamp;
    @(posedge core_clk_i);
    display_segment_test_i <= 1'h1;
    repeat (8) @(posedge core_clk_i);
    chk_drv({cur[7:4], 4'hc});
    display_segment_test_i <= 1'h0;
    repeat (8) @(posedge core_clk_i);
    chk_drv(cur);
  endtask
  task automatic wait_wave(input logic v, output time t);
    int k;
    k = 0;
    while (wave !== v && k < 20000) begin
      @(posedge core_clk_i);
      k++;
    end
    t = $time;
    if (k >= 20000) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // One wave period is 1600 input edges of 40 ns
  task automatic t_wave;
    time t0, t1, t2;
    wait_wave(1'h0, t0);
    wait_wave(1'h1, t0);
    @(posedge core_clk_i);
    chk({31'h0, rise_n}, 32'h0);
    @(posedge core_clk_i);
    chk({31'h0, rise_n}, 32'h1);
    wait_wave(1'h0, t1);
    @(posedge core_clk_i);
    chk({31'h0, fall_n}, 32'h0);
    @(posedge core_clk_i);
    chk({31'h0, fall_n}, 32'h1);
    wait_wave(1'h1, t2);
    chk(32'(t1 - t0), 32'h7d00);
    chk(32'(t2 - t0), 32'hfa00);
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    arst_n_i <= 1'h1;
    t_reset();
    t_modes();
    t_load_en();
    t_reject();
    t_lamp();
    t_wave();
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: dv/fmrd_ctl_model.sv
// Earthy-side controller model: command bursts and forcing clock.
// Assumes callers start a burst only after the previous one returned.
`timescale 1ns/1ps
`default_nettype none
module fmrd_ctl_model (
  // Opto-coupled lines toward the decoder
  output logic clk_1m6_o,
  output logic serial_data_o,
  output logic serial_strobe_o
);
  initial begin
    clk_1m6_o = 1'h0;
    serial_data_o = 1'h0;
    serial_strobe_o = 1'h0;
  end
  // Sped up from 1.6 MHz so a wave period fits the run
  always #20 clk_1m6_o = ~clk_1m6_o;
  // First bit sent is bit 7; strobe idles low between bursts
  task automatic send(input logic [7:0] w, input int n);
    #1;
    for (int i = 0; i < n; i++) begin
      serial_data_o = w[7 - (i % 8)];
      #20 serial_strobe_o = 1'h1;
      #20 serial_strobe_o = 1'h0;
    end
    // Released line must not show a held bit
    serial_data_o = ~serial_data_o;
    #5200;
  endtask
endmodule
`default_nettype wire

// File: dv/fmrd_decoder_sva.sv
// Checker for the floating mode/range decoder, bound to its top module.
// Assumes the forcing clock pin toggles slower than every third core cycle.
`timescale 1ns/1ps
`default_nettype none
module fmrd_decoder_sva
  import fmrd_pkg::*;
(
  // Clock, reset and pins
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_1m6_i,
  input wire logic display_segment_test_i,
  // Decoder outputs
  input wire fmrd_drive_t drives_o,
  input wire logic integrator_force_wave_o,
  input wire logic force_rise_edge_pulse_n_o,
  input wire logic force_fall_edge_pulse_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic clk_q;
  logic wave_q;
  logic [10:0] rise_cnt;
  // Input edges seen per wave half; sync latency cancels out between halves
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_q <= 1'h0;
      wave_q <= 1'h0;
      rise_cnt <= 11'h0;
    end else begin
      clk_q <= clk_1m6_i;
      wave_q <= integrator_force_wave_o;
      if (wave_q != integrator_force_wave_o) begin
        rise_cnt <= {10'h0, clk_1m6_i & ~clk_q};
      end else begin
        rise_cnt <= rise_cnt + {10'h0, clk_1m6_i & ~clk_q};
      end
    end
  end
  property p_one_mode;
    $past(arst_n_i) |-> $onehot(~{drives_o.dc_mode_n, drives_o.ac_mode_n,
      drives_o.ohms_mode_n, drives_o.selftest_n});
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode lines not one-hot");
  property p_ac_path;
    !drives_o.ac_mode_n |-> $onehot({drives_o.ac_direct_path_relay,
      drives_o.ac_kilo_atten_relay, drives_o.ac_attenuator_control});
  endproperty
  a_ac_path: assert property (p_ac_path) else $error("ac path not single");
  property p_x10;
    drives_o.ac_buffer_x10 |-> drives_o.ac_attenuator_control && !drives_o.ac_mode_n;
  endproperty
  a_x10: assert property (p_x10) else $error("buffer gain outside 10 V ac");
  property p_ohms_cur;
    !drives_o.ohms_mode_n |-> !(drives_o.high_current_switch && drives_o.mid_current_switch)
      && !drives_o.ohms_selfcheck_relay;
  endproperty
  a_ohms_cur: assert property (p_ohms_cur) else $error("current switches clash");
  property p_ohms_check;
    !drives_o.selftest_n[3] |-> drives_o.high_current_switch && drives_o.ohms_selfcheck_relay;
  endproperty
  a_ohms_check: assert property (p_ohms_check) else $error("ohms check drive wrong");
  property p_dc_gain;
    !drives_o.dc_mode_n |-> $onehot(drives_o.dc_gain_switch);
  endproperty
  a_dc_gain: assert property (p_dc_gain) else $error("dc gain not one-hot");
  property p_lamp;
    display_segment_test_i [*6] |-> drives_o.selftest_n == 4'he;
  endproperty
  a_lamp: assert property (p_lamp) else $error("display_segment_test not test one");
  property p_wave;
    $changed(integrator_force_wave_o) |-> rise_cnt >= 11'h31f && rise_cnt <= 11'h321;
  endproperty
  a_wave: assert property (p_wave) else $error("wave half not 800 edges");
  property p_rise;
    $rose(integrator_force_wave_o) |-> ##[0:2] !force_rise_edge_pulse_n_o
      ##1 force_rise_edge_pulse_n_o;
  endproperty
  a_rise: assert property (p_rise) else $error("rise pulse missing");
  property p_fall;
    $fell(integrator_force_wave_o) |-> ##[0:2] !force_fall_edge_pulse_n_o
      ##1 force_fall_edge_pulse_n_o;
  endproperty
  a_fall: assert property (p_fall) else $error("fall pulse missing");
endmodule
bind fmrd_decoder fmrd_decoder_sva u_sva (.core_clk_i, .arst_n_i, .clk_1m6_i,
  .display_segment_test_i, .drives_o, .integrator_force_wave_o,
  .force_rise_edge_pulse_n_o, .force_fall_edge_pulse_n_o);
`default_nettype wire
